/* inc/clk_params.svh */
`ifndef CLK_PARAMS_SVH
`define CLK_PARAMS_SVH

// Register byte offsets
`define OFS_CLOCK_MODE_CTL  8'h00
`define OFS_CLOCK_RUN_CTL   8'h04
`define OFS_STAB_TIME_SEL   8'h08
`define OFS_STAB_COUNT_STAT 8'h0c
`define OFS_SYS_CLOCK_CTL   8'h10

// Field positions
`define BIT_EXT_CLOCK_IN_SEL 7
`define BIT_OSC_PIN_ENABLE   6
`define BIT_HIGH_GAIN_SEL    0
`define BIT_MAIN_OSC_HALT    7
`define BIT_INTERNAL_OSC_HALT 0
`define BIT_MAIN_SRC_STATUS  5
`define BIT_MAIN_SRC_SEL     4

// Reset values
`define RST_MAIN_OSC_HALT     1'b1
`define RST_INTERNAL_OSC_HALT 1'b0
`define RST_STAB_TIME_SEL     3'h7

// Stabilisation thresholds, as powers of two of main clock cycles
`define STAB_EXP_LIST {5'd18, 5'd17, 5'd15, 5'd13, 5'd11, 5'd10, 5'd9, 5'd8}

// Cycles on the old clock before a source switch takes effect
`define SWITCH_CLKS 4'd3

`endif

/* inc/clk_pkg.sv */
package clk_pkg;

    // Gray coded along run -> switch -> run and halt branches; stop entries flip two bits
    typedef enum logic [2:0] {
        RUN_INT   = 3'b000,
        SWITCHING = 3'b001,
        RUN_MAIN  = 3'b011,
        HALT_MAIN = 3'b010,
        STOP_MAIN = 3'b110,
        WAKE_WAIT = 3'b111,
        STOP_INT  = 3'b101,
        HALT_INT  = 3'b100
    } clk_state_type;

endpackage : clk_pkg

/* src/cycle_timer.sv */
`timescale 1ns/100ps

// Loadable down counter; done is high once the loaded count has run out
module cycle_timer #(
    parameter int WIDTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  done
);

    logic [WIDTH-1:0] remain;

    // Reload wins over counting so a restart is never missed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            remain <= '0;
        else if (load)
            remain <= count;
        else if (remain != '0)
            remain <= remain - 1'b1;
    end

    assign done = (remain == '0) && !load;

endmodule : cycle_timer

/* src/clock_src_fsm.sv */
// Behaviour
// - After any reset the CPU runs on the internal oscillator; main oscillator stopped.
// - Internal oscillator reads as running straight after reset, no software start needed.
// - Oscillator pins act as input port until software enables oscillator operation.
// - Clock mode control register takes one write after reset; later writes ignored.
// - HALT on the internal oscillator enters its own HALT, oscillator kept running.
// - HALT on the main clock enters a separate HALT, main oscillator kept running.
// - STOP from internal oscillator halts both internal and main oscillators.
// - After a source select write the old clock runs a bounded count before switching.
// - Source status bit 5 of the system clock control register shows the active source.
// - No direct switch between crystal and external clock; none is provided.
`timescale 1ns/100ps
`include "clk_params.svh"

module clock_src_fsm #(
    parameter int STAB_SHIFT = 0 // Shortens stabilisation thresholds for simulation
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt_req,
    input  wire logic        stop_req,
    input  wire logic        wake_req,
    output logic             internal_osc_run,
    output logic             main_osc_run,
    output logic             osc_pins_as_port,
    output logic             cpu_clk_sel,
    output logic             cpu_clk_en,
    output logic             cpu_halted,
    output logic             cpu_stopped
);

    localparam logic [39:0] STAB_EXP = `STAB_EXP_LIST;

    clk_pkg::clk_state_type state;
    clk_pkg::clk_state_type next_state;

    logic        ext_clock_in_sel;
    logic        osc_pin_enable;
    logic        high_gain_sel;
    logic        mode_written;
    logic        main_osc_halt;
    logic        internal_osc_halt;
    logic [2:0]  stab_time_sel;
    logic        main_src_sel;
    logic        main_src_status;
    logic        target_main;
    logic        gap;
    logic [18:0] stab_count;
    logic [7:0]  stab_count_status;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        sel_write;
    logic        switch_done;
    logic        stab_ready;

    // Single-cycle access phase: every transfer completes at once
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign addr_ok = (paddr == `OFS_CLOCK_MODE_CTL) || (paddr == `OFS_CLOCK_RUN_CTL)
                  || (paddr == `OFS_STAB_TIME_SEL) || (paddr == `OFS_STAB_COUNT_STAT)
                  || (paddr == `OFS_SYS_CLOCK_CTL);
    assign pslverr = psel && penable && !addr_ok;
    assign sel_write = wr_en && (paddr == `OFS_SYS_CLOCK_CTL);

    // Clock mode control: write once, then locked until reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_clock_in_sel <= 1'b0;
            osc_pin_enable   <= 1'b0;
            high_gain_sel    <= 1'b0;
            mode_written     <= 1'b0;
        end
        else if (wr_en && (paddr == `OFS_CLOCK_MODE_CTL) && !mode_written)
        begin
            ext_clock_in_sel <= pwdata[`BIT_EXT_CLOCK_IN_SEL];
            osc_pin_enable   <= pwdata[`BIT_OSC_PIN_ENABLE];
            high_gain_sel    <= pwdata[`BIT_HIGH_GAIN_SEL];
            mode_written     <= 1'b1;
        end
    end

    // Oscillator run control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_osc_halt     <= `RST_MAIN_OSC_HALT;
            internal_osc_halt <= `RST_INTERNAL_OSC_HALT;
        end
        else if (wr_en && (paddr == `OFS_CLOCK_RUN_CTL))
        begin
            main_osc_halt     <= pwdata[`BIT_MAIN_OSC_HALT];
            internal_osc_halt <= pwdata[`BIT_INTERNAL_OSC_HALT];
        end
    end

    // Stabilisation time select, read at STOP release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stab_time_sel <= `RST_STAB_TIME_SEL;
        else if (wr_en && (paddr == `OFS_STAB_TIME_SEL))
            stab_time_sel <= pwdata[2:0];
    end

    // Source select request; status moves only when the switch completes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            main_src_sel <= 1'b0;
        else if (sel_write)
            main_src_sel <= pwdata[`BIT_MAIN_SRC_SEL];
    end

    // An oscillator the CPU is using is never stopped, even if software asks
    assign internal_osc_run = !cpu_stopped && (!internal_osc_halt || !main_src_status
                                                || (state == clk_pkg::SWITCHING));
    // Main oscillator restarts in the stop wake wait, else its stabilisation count could never run
    assign main_osc_run     = osc_pin_enable && (!cpu_stopped || (state == clk_pkg::WAKE_WAIT))
                           && (!main_osc_halt || main_src_status
                               || (state == clk_pkg::SWITCHING));
    assign osc_pins_as_port = !osc_pin_enable;

    // Main oscillator stabilisation counter, restarted whenever it stops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stab_count <= '0;
        else if (!main_osc_run)
            stab_count <= '0;
        else if (stab_count != '1)
            stab_count <= stab_count + 1'b1;
    end

    // One status bit per threshold, bit 7 being the shortest wait
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_stab
            localparam int EXP = int'(STAB_EXP[gi*5 +: 5]) - STAB_SHIFT;
            assign stab_count_status[7-gi] = (stab_count >= 19'(1 << EXP));
        end
    endgenerate

    // Wake wait length follows the select; an external clock needs none
    assign stab_ready = ext_clock_in_sel || stab_count_status[3'd7 - stab_time_sel];

    // Switch delay on the old clock before the hand-over
    cycle_timer #(
        .WIDTH (4)
    ) u_switch_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (state != clk_pkg::SWITCHING),
        .count   (`SWITCH_CLKS),
        .done    (switch_done)
    );

    // CPU clock state machine
    always_comb
    begin
        next_state = state;
        case (state)
            clk_pkg::RUN_INT:
            begin
                if (stop_req)
                    next_state = clk_pkg::STOP_INT;
                else if (halt_req)
                    next_state = clk_pkg::HALT_INT;
                else if (sel_write && pwdata[`BIT_MAIN_SRC_SEL] && main_osc_run)
                    next_state = clk_pkg::SWITCHING;
            end
            clk_pkg::RUN_MAIN:
            begin
                if (stop_req)
                    next_state = clk_pkg::STOP_MAIN;
                else if (halt_req)
                    next_state = clk_pkg::HALT_MAIN;
                else if (sel_write && !pwdata[`BIT_MAIN_SRC_SEL] && !internal_osc_halt)
                    next_state = clk_pkg::SWITCHING;
            end
            clk_pkg::SWITCHING:
            begin
                if (switch_done && gap)
                    next_state = target_main ? clk_pkg::RUN_MAIN : clk_pkg::RUN_INT;
            end
            clk_pkg::HALT_INT:
            begin
                if (wake_req)
                    next_state = clk_pkg::RUN_INT;
            end
            clk_pkg::HALT_MAIN:
            begin
                if (wake_req)
                    next_state = clk_pkg::RUN_MAIN;
            end
            clk_pkg::STOP_INT:
            begin
                if (wake_req)
                    next_state = clk_pkg::RUN_INT;
            end
            clk_pkg::STOP_MAIN:
            begin
                if (wake_req)
                    next_state = clk_pkg::WAKE_WAIT;
            end
            clk_pkg::WAKE_WAIT:
            begin
                if (stab_ready)
                    next_state = clk_pkg::RUN_MAIN;
            end
            default:
                next_state = clk_pkg::RUN_INT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= clk_pkg::RUN_INT;
        else
            state <= next_state;
    end

    // Remember which way a switch goes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            target_main <= 1'b0;
        else if (state != clk_pkg::SWITCHING)
            target_main <= pwdata[`BIT_MAIN_SRC_SEL];
    end

    // Dead cycle with the CPU clock gated before the mux moves; no runt pulse reaches the CPU
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap <= 1'b0;
        else
            gap <= (state == clk_pkg::SWITCHING) && switch_done && !gap;
    end

    // Active source follows the state, not the request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            main_src_status <= 1'b0;
        else if ((state == clk_pkg::SWITCHING) && switch_done && gap)
            main_src_status <= target_main;
    end

    // Clock mux select and gate outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_clk_sel <= 1'b0;
            cpu_clk_en  <= 1'b1;
            cpu_halted  <= 1'b0;
            cpu_stopped <= 1'b0;
        end
        else
        begin
            cpu_clk_sel <= (next_state == clk_pkg::RUN_MAIN) || (next_state == clk_pkg::HALT_MAIN)
                        || (next_state == clk_pkg::STOP_MAIN) || (next_state == clk_pkg::WAKE_WAIT)
                        || ((next_state == clk_pkg::SWITCHING) && main_src_status);
            cpu_clk_en  <= (next_state == clk_pkg::RUN_INT) || (next_state == clk_pkg::RUN_MAIN)
                        || ((next_state == clk_pkg::SWITCHING)
                            && !((state == clk_pkg::SWITCHING) && switch_done));
            cpu_halted  <= (next_state == clk_pkg::HALT_INT) || (next_state == clk_pkg::HALT_MAIN);
            cpu_stopped <= (next_state == clk_pkg::STOP_INT) || (next_state == clk_pkg::STOP_MAIN)
                        || (next_state == clk_pkg::WAKE_WAIT);
        end
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `OFS_CLOCK_MODE_CTL:
                begin
                    prdata[`BIT_EXT_CLOCK_IN_SEL] <= ext_clock_in_sel;
                    prdata[`BIT_OSC_PIN_ENABLE]   <= osc_pin_enable;
                    prdata[`BIT_HIGH_GAIN_SEL]    <= high_gain_sel;
                end
                `OFS_CLOCK_RUN_CTL:
                begin
                    prdata[`BIT_MAIN_OSC_HALT]     <= main_osc_halt;
                    prdata[`BIT_INTERNAL_OSC_HALT] <= internal_osc_halt;
                end
                `OFS_STAB_TIME_SEL:
                    prdata[2:0] <= stab_time_sel;
                `OFS_STAB_COUNT_STAT:
                    prdata[7:0] <= stab_count_status;
                `OFS_SYS_CLOCK_CTL:
                begin
                    prdata[`BIT_MAIN_SRC_STATUS] <= main_src_status;
                    prdata[`BIT_MAIN_SRC_SEL]    <= main_src_sel;
                end
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : clock_src_fsm

/* bench/clock_src_fsm_asserts.sv */
`timescale 1ns/100ps

module clock_src_fsm_asserts #(
    parameter int STAB_SHIFT = 0
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        halt_req,
    input wire logic        stop_req,
    input wire logic        internal_osc_run,
    input wire logic        main_osc_run,
    input wire logic        osc_pins_as_port,
    input wire logic        cpu_clk_sel,
    input wire logic        cpu_clk_en,
    input wire logic        cpu_halted,
    input wire logic        cpu_stopped
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Select write that the block must act on; bench never writes mid-switch
    sequence take_switch;
        psel && penable && pwrite && paddr == 8'h10 && !cpu_halted && !cpu_stopped &&
        ((pwdata[4] && !cpu_clk_sel && main_osc_run) || (!pwdata[4] && cpu_clk_sel && internal_osc_run));
    endsequence
    // Old clock still drives the CPU while the timer runs
    sequence old_clock_holds;
        $stable(cpu_clk_sel)[*3];
    endsequence

    chk_int_osc_used: assert property (!cpu_stopped && !cpu_clk_sel |-> internal_osc_run)
        else $error("internal oscillator off while in use");
    chk_main_osc_used: assert property (!cpu_stopped && cpu_clk_sel |-> main_osc_run)
        else $error("main oscillator off while in use");
    chk_port_pins_idle: assert property (osc_pins_as_port |-> !main_osc_run)
        else $error("main oscillator runs with pins as port");
    chk_stop_int_off: assert property (cpu_stopped && !cpu_clk_sel |-> !internal_osc_run && !main_osc_run)
        else $error("oscillator running in internal stop");
    chk_halt_cause: assert property ($rose(cpu_halted) |-> $past(halt_req))
        else $error("halt entered without request");
    chk_stop_cause: assert property ($rose(cpu_stopped) |-> $past(stop_req))
        else $error("stop entered without request");
    chk_sel_kept: assert property (cpu_halted || cpu_stopped |-> $stable(cpu_clk_sel))
        else $error("source changed in standby");
    chk_gap_cycle: assert property ($changed(cpu_clk_sel) |-> !$past(cpu_clk_en) && cpu_clk_en)
        else $error("source changed without one gated cycle");
    chk_switch_delay: assert property (take_switch |=> old_clock_holds ##[1:3] $changed(cpu_clk_sel))
        else $error("switch timing wrong");
    chk_apb_ready: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
endmodule : clock_src_fsm_asserts

bind clock_src_fsm clock_src_fsm_asserts #(.STAB_SHIFT(STAB_SHIFT)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .halt_req(halt_req), .stop_req(stop_req),
    .internal_osc_run(internal_osc_run), .main_osc_run(main_osc_run),
    .osc_pins_as_port(osc_pins_as_port), .cpu_clk_sel(cpu_clk_sel), .cpu_clk_en(cpu_clk_en),
    .cpu_halted(cpu_halted), .cpu_stopped(cpu_stopped));

/* bench/testbench.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end

module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        halt_req = 1'b0, stop_req = 1'b0, wake_req = 1'b0;
    logic        internal_osc_run, main_osc_run, osc_pins_as_port;
    logic        cpu_clk_sel, cpu_clk_en, cpu_halted, cpu_stopped;
    int          n_errors = 0, compares = 0, i;

    always #2.5 pclk = ~pclk;

    // Shift 8 shortens the stabilisation thresholds to 2^0..2^10 cycles
    clock_src_fsm #(.STAB_SHIFT(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_req(halt_req), .stop_req(stop_req), .wake_req(wake_req),
        .internal_osc_run(internal_osc_run), .main_osc_run(main_osc_run),
        .osc_pins_as_port(osc_pins_as_port), .cpu_clk_sel(cpu_clk_sel), .cpu_clk_en(cpu_clk_en),
        .cpu_halted(cpu_halted), .cpu_stopped(cpu_stopped));

    // One APB transfer; starts a cycle late so no strobe is driven twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rd_chk

    // Order of v is halt, stop, wake
    task automatic pulse(input logic [2:0] v);
        @(posedge pclk);
        {halt_req, stop_req, wake_req} <= v;
        @(posedge pclk);
        {halt_req, stop_req, wake_req} <= 3'h0;
        repeat (2) @(posedge pclk);
        #1;
    endtask : pulse

    task automatic wait_run();
        for (i = 0; i < 200 && cpu_stopped !== 1'b0; i++)
            @(posedge pclk);
        #1;
    endtask : wait_run

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // Tests
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK({internal_osc_run, main_osc_run, osc_pins_as_port, cpu_clk_sel}, 4'b1010)
        rd_chk(8'h04, 32'h80);
        rd_chk(8'h08, 32'h7);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h14, 32'h0);
        `CHK(err, 1'b1)
        done("reset");
        pulse(3'b100);
        `CHK({cpu_halted, internal_osc_run, cpu_clk_en}, 3'b110)
        pulse(3'b001);
        `CHK({cpu_halted, cpu_clk_sel, cpu_clk_en}, 3'b001)
        pulse(3'b010);
        `CHK({cpu_stopped, internal_osc_run, main_osc_run}, 3'b100)
        pulse(3'b001);
        wait_run();
        `CHK({cpu_stopped, internal_osc_run}, 2'b01)
        done("standby_internal");
        apb(1'b1, 8'h00, 32'h41);
        apb(1'b1, 8'h00, 32'h80);
        rd_chk(8'h00, 32'h41);
        apb(1'b1, 8'h08, 32'h3);
        apb(1'b1, 8'h04, 32'h0);
        #1;
        `CHK({main_osc_run, osc_pins_as_port}, 2'b10)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd[0], 1'b0)
        // Longest threshold is 2^10 cycles, a read takes three
        for (i = 0; i < 1000 && rd[7:0] !== 8'hff; i++)
            apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd[7:0], 8'hff)
        done("start_main");
        apb(1'b1, 8'h10, 32'h10);
        rd_chk(8'h10, 32'h10);
        repeat (8) @(posedge pclk);
        rd_chk(8'h10, 32'h30);
        `CHK(cpu_clk_sel, 1'b1)
        pulse(3'b100);
        `CHK({cpu_halted, main_osc_run}, 2'b11)
        pulse(3'b001);
        `CHK({cpu_halted, cpu_clk_sel}, 2'b01)
        pulse(3'b010);
        `CHK({cpu_stopped, main_osc_run}, 2'b10)
        pulse(3'b001);
        `CHK({cpu_stopped, main_osc_run}, 2'b11)
        wait_run();
        `CHK({cpu_stopped, cpu_clk_sel}, 2'b01)
        done("main_clock");
        // Internal halted: the switch back must be refused
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h10, 32'h0);
        repeat (8) @(posedge pclk);
        rd_chk(8'h10, 32'h20);
        apb(1'b1, 8'h04, 32'h0);
        repeat (5400) @(posedge pclk);
        apb(1'b1, 8'h10, 32'h0);
        repeat (8) @(posedge pclk);
        rd_chk(8'h10, 32'h0);
        `CHK(cpu_clk_sel, 1'b0)
        done("back_internal");
        // A new reset opens the write-once register again
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h00, 32'hc0);
        rd_chk(8'h00, 32'hc0);
        `CHK({cpu_clk_sel, internal_osc_run}, 2'b01)
        // External clock wakes from STOP at once, with the select left at its reset value 7, the longest wait
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h10, 32'h10);
        repeat (8) @(posedge pclk);
        pulse(3'b010);
        pulse(3'b001);
        `CHK({cpu_stopped, cpu_clk_sel, main_osc_run}, 3'b011)
        done("second_reset");
        // Crystal at low gain after a fresh reset
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h00, 32'h40);
        rd_chk(8'h00, 32'h40);
        done("third_reset");
        complete_run();
    end

    // Tests need about 6600 cycles
    initial
    begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        complete_run();
    end
endmodule : testbench
